// ---- crs_pkg.sv ----
// Package for the CPU register set: widths, register numbers and status layout
package crs_pkg;
  localparam int unsigned XLEN       = 32;
  localparam int unsigned GPR_IDX_W  = 5;
  localparam int unsigned PC_VALID_W = 26;
  localparam int unsigned STAT_W     = 8;

  localparam logic [4:0] GPR_ZERO         = 5'h00;
  localparam logic [4:0] GPR_ELEMENT_BASE = 5'h1e;

  localparam logic [4:0] SR_IRQ_PC   = 5'h00;
  localparam logic [4:0] SR_IRQ_ST   = 5'h01;
  localparam logic [4:0] SR_NMI_PC   = 5'h02;
  localparam logic [4:0] SR_NMI_ST   = 5'h03;
  localparam logic [4:0] SR_CAUSE    = 5'h04;
  localparam logic [4:0] SR_STATUS   = 5'h05;
  localparam logic [4:0] SR_TC_PC    = 5'h10;
  localparam logic [4:0] SR_TC_ST    = 5'h11;
  localparam logic [4:0] SR_DBG_PC   = 5'h12;
  localparam logic [4:0] SR_DBG_ST   = 5'h13;
  localparam logic [4:0] SR_TC_BASE  = 5'h14;

  localparam logic [31:0] PC_KEEP_MASK = 32'h03fffffe;
  localparam logic [31:0] STAT_MASK    = 32'h000000ff;
  localparam logic [31:0] ZERO_WORD    = 32'h00000000;

  typedef enum logic [1:0] {
    CRS_RET_IRQ,
    CRS_RET_NMI,
    CRS_RET_TC
  } crs_ret_e;

  // Status word flags, bit 7 down to bit 0
  typedef struct packed {
    logic nmiActive;
    logic excActive;
    logic irqDisable;
    logic saturation;
    logic carry;
    logic overflow;
    logic sign;
    logic zero;
  } crs_stat_s;

  // One pipeline write request for a register
  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [31:0] data;
  } crs_wr_s;

  // Program counter update request
  typedef struct packed {
    logic        jump;
    logic [31:0] target;
    logic        ret;
    crs_ret_e    retSrc;
  } crs_pc_s;
endpackage

// ---- crs_register_set.sv ----
// CPU architectural register set: general registers, program counter, system registers
`timescale 1ns/10ps
module crs_register_set
  import crs_pkg::*;
#(
  parameter int unsigned NUM_GPR = 32
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [GPR_IDX_W-1:0]       rdAddrA,
  input  wire logic [GPR_IDX_W-1:0]       rdAddrB,
  input  wire logic                       shortMemAccess,
  input  wire crs_pkg::crs_wr_s           gprWr,
  input  wire crs_pkg::crs_pc_s           pcReq,
  input  wire logic                       pcAdvance,
  input  wire logic [XLEN-1:0]            pcStep,
  input  wire logic                       loadSysRegInstr,
  input  wire logic                       storeSysRegInstr,
  input  wire logic [4:0]                 sysRegNum,
  input  wire logic [XLEN-1:0]            sysWrData,
  input  wire logic                       debugTrapInstr,
  input  wire crs_pkg::crs_wr_s           hwSave,
  input  wire logic                       flagWrEn,
  input  wire crs_pkg::crs_stat_s         flagWrData,
  input  wire logic                       causeWrEn,
  input  wire logic [XLEN-1:0]            causeWrData,
  output logic [XLEN-1:0]                 rdDataA,
  output logic [XLEN-1:0]                 rdDataB,
  output logic [XLEN-1:0]                 memBase,
  output logic [XLEN-1:0]                 pcOut,
  output logic [XLEN-1:0]                 sysRdData,
  output crs_pkg::crs_stat_s              statusOut,
  output logic [XLEN-1:0]                 tableCallBaseOut
);
  import crs_pkg::*;

  // Returns the legal program counter image of any value
  function automatic logic [XLEN-1:0] pcLegal(input logic [XLEN-1:0] v);
    pcLegal = v & PC_KEEP_MASK;
  endfunction

  function automatic logic [XLEN-1:0] gprRead(input logic [XLEN-1:0] f [NUM_GPR],
                                               input logic [GPR_IDX_W-1:0] a);
    gprRead = (a == GPR_ZERO) ? ZERO_WORD : f[a];
  endfunction

  logic [XLEN-1:0] gpr_q [NUM_GPR];
  logic [XLEN-1:0] gpr_d [NUM_GPR];
  logic [XLEN-1:0] pc_q, pc_d;
  logic [XLEN-1:0] irqPc_q, irqPc_d, irqSt_q, irqSt_d;
  logic [XLEN-1:0] nmiPc_q, nmiPc_d, nmiSt_q, nmiSt_d;
  logic [XLEN-1:0] cause_q, cause_d;
  crs_stat_s       stat_q, stat_d;
  logic [XLEN-1:0] tcPc_q, tcPc_d, tcSt_q, tcSt_d;
  logic [XLEN-1:0] dbgPc_q, dbgPc_d, dbgSt_q, dbgSt_d;
  logic [XLEN-1:0] tcBase_q, tcBase_d;
  logic [XLEN-1:0] rdA_q, rdA_d, rdB_q, rdB_d, base_q, base_d, sysRd_q, sysRd_d;
  logic            load_system_reg_instr;
  logic [XLEN-1:0] sysWord;

  // General registers; zero register never stored
  always_comb begin
    for (int i = 0; i < NUM_GPR; i++) begin
      gpr_d[i] = gpr_q[i];
    end
    if (gprWr.en && gprWr.idx != GPR_ZERO) begin
      gpr_d[gprWr.idx] = gprWr.data;
    end
    gpr_d[GPR_ZERO] = ZERO_WORD;
    // Registered reads see the old file; pipeline forwards if needed
    rdA_d  = gprRead(gpr_q, rdAddrA);
    rdB_d  = gprRead(gpr_q, rdAddrB);
    base_d = shortMemAccess ? gpr_q[GPR_ELEMENT_BASE] : rdA_d;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_q[i] <= ZERO_WORD;
      end
      rdA_q  <= ZERO_WORD;
      rdB_q  <= ZERO_WORD;
      base_q <= ZERO_WORD;
    end else begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_q[i] <= gpr_d[i];
      end
      rdA_q  <= rdA_d;
      rdB_q  <= rdB_d;
      base_q <= base_d;
    end
  end

  // Program counter: return beats jump beats sequential advance
  always_comb begin
    pc_d = pc_q;
    if (pcReq.ret) begin
      unique case (pcReq.retSrc)
        CRS_RET_IRQ: pc_d = pcLegal(irqPc_q);
        CRS_RET_NMI: pc_d = pcLegal(nmiPc_q);
        CRS_RET_TC:  pc_d = pcLegal(tcPc_q);
        default:     pc_d = pc_q;
      endcase
    end else if (pcReq.jump) begin
      pc_d = pcLegal(pcReq.target);
    end else if (pcAdvance) begin
      pc_d = pcLegal(pc_q + pcStep);
    end
  end

  // System registers: loads first, then hardware saves on exceptions win
  assign load_system_reg_instr = loadSysRegInstr && !storeSysRegInstr;

  always_comb begin
    irqPc_d  = irqPc_q;
    irqSt_d  = irqSt_q;
    nmiPc_d  = nmiPc_q;
    nmiSt_d  = nmiSt_q;
    cause_d  = cause_q;
    stat_d   = stat_q;
    tcPc_d   = tcPc_q;
    tcSt_d   = tcSt_q;
    dbgPc_d  = dbgPc_q;
    dbgSt_d  = dbgSt_q;
    tcBase_d = tcBase_q;
    if (flagWrEn) begin
      stat_d = flagWrData;
    end
    if (causeWrEn) begin
      cause_d = causeWrData;
    end
    if (load_system_reg_instr) begin
      // Reserved numbers and the cause register fall through untouched
      unique case (sysRegNum)
        SR_IRQ_PC:  irqPc_d  = sysWrData;
        SR_IRQ_ST:  irqSt_d  = sysWrData;
        SR_NMI_PC:  nmiPc_d  = sysWrData;
        SR_NMI_ST:  nmiSt_d  = sysWrData;
        SR_STATUS:  stat_d   = crs_stat_s'(sysWrData[STAT_W-1:0]);
        SR_TC_PC:   tcPc_d   = sysWrData;
        SR_TC_ST:   tcSt_d   = sysWrData;
        SR_DBG_PC:  if (debugTrapInstr) dbgPc_d = sysWrData;
        SR_DBG_ST:  if (debugTrapInstr) dbgSt_d = sysWrData;
        SR_TC_BASE: tcBase_d = sysWrData;
        default:    cause_d  = cause_d;
      endcase
    end
    // Hardware saves on interrupt, NMI, table call or trap
    if (hwSave.en) begin
      unique case (hwSave.idx)
        SR_IRQ_PC: irqPc_d = hwSave.data;
        SR_IRQ_ST: irqSt_d = hwSave.data;
        SR_NMI_PC: nmiPc_d = hwSave.data;
        SR_NMI_ST: nmiSt_d = hwSave.data;
        SR_TC_PC:  tcPc_d  = hwSave.data;
        SR_TC_ST:  tcSt_d  = hwSave.data;
        SR_DBG_PC: dbgPc_d = hwSave.data;
        SR_DBG_ST: dbgSt_d = hwSave.data;
        default:   tcBase_d = tcBase_d;
      endcase
    end
  end

  // Store-system-register read mux; reserved numbers read zero
  always_comb begin
    unique case (sysRegNum)
      SR_IRQ_PC:  sysWord = irqPc_q;
      SR_IRQ_ST:  sysWord = irqSt_q;
      SR_NMI_PC:  sysWord = nmiPc_q;
      SR_NMI_ST:  sysWord = nmiSt_q;
      SR_CAUSE:   sysWord = cause_q;
      SR_STATUS:  sysWord = {{(XLEN-STAT_W){1'b0}}, stat_q} & STAT_MASK;
      SR_TC_PC:   sysWord = tcPc_q;
      SR_TC_ST:   sysWord = tcSt_q;
      SR_DBG_PC:  sysWord = dbgPc_q;
      SR_DBG_ST:  sysWord = dbgSt_q;
      SR_TC_BASE: sysWord = tcBase_q;
      default:    sysWord = ZERO_WORD;
    endcase
    sysRd_d = storeSysRegInstr ? sysWord : sysRd_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q     <= ZERO_WORD;
      irqPc_q  <= ZERO_WORD;
      irqSt_q  <= ZERO_WORD;
      nmiPc_q  <= ZERO_WORD;
      nmiSt_q  <= ZERO_WORD;
      cause_q  <= ZERO_WORD;
      stat_q   <= '0;
      tcPc_q   <= ZERO_WORD;
      tcSt_q   <= ZERO_WORD;
      dbgPc_q  <= ZERO_WORD;
      dbgSt_q  <= ZERO_WORD;
      tcBase_q <= ZERO_WORD;
      sysRd_q  <= ZERO_WORD;
    end else begin
      pc_q     <= pc_d;
      irqPc_q  <= irqPc_d;
      irqSt_q  <= irqSt_d;
      nmiPc_q  <= nmiPc_d;
      nmiSt_q  <= nmiSt_d;
      cause_q  <= cause_d;
      stat_q   <= stat_d;
      tcPc_q   <= tcPc_d;
      tcSt_q   <= tcSt_d;
      dbgPc_q  <= dbgPc_d;
      dbgSt_q  <= dbgSt_d;
      tcBase_q <= tcBase_d;
      sysRd_q  <= sysRd_d;
    end
  end

  assign rdDataA          = rdA_q;
  assign rdDataB          = rdB_q;
  assign memBase          = base_q;
  assign pcOut            = pc_q;
  assign sysRdData        = sysRd_q;
  assign statusOut        = stat_q;
  assign tableCallBaseOut = tcBase_q;
endmodule

// ---- crs_register_set_monitor.sv ----
// Port-level checker for the CPU register set
`timescale 1ns/10ps
module crs_register_set_monitor
  import crs_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic [GPR_IDX_W-1:0] rdAddrA,
  input wire logic                 shortMemAccess,
  input wire crs_pkg::crs_pc_s     pcReq,
  input wire logic                 pcAdvance,
  input wire logic [XLEN-1:0]      pcStep,
  input wire logic                 loadSysRegInstr,
  input wire logic                 storeSysRegInstr,
  input wire logic [4:0]           sysRegNum,
  input wire logic [XLEN-1:0]      sysWrData,
  input wire logic [XLEN-1:0]      rdDataA,
  input wire logic [XLEN-1:0]      memBase,
  input wire logic [XLEN-1:0]      pcOut,
  input wire logic [XLEN-1:0]      sysRdData,
  input wire crs_pkg::crs_stat_s   statusOut,
  input wire logic [XLEN-1:0]      tableCallBaseOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pcHigh; pcOut[31:26] == 6'h00; endproperty
  a_pcHigh: assert property (p_pcHigh) else $error("pc upper bits set");
  property p_pcEven; pcOut[0] == 1'b0; endproperty
  a_pcEven: assert property (p_pcEven) else $error("pc odd");
  property p_zeroRd; rdAddrA == 5'h00 |=> rdDataA == 32'h0; endproperty
  a_zeroRd: assert property (p_zeroRd) else $error("register zero not zero");
  property p_shortBase; shortMemAccess && rdAddrA == 5'h1e |=> memBase == rdDataA; endproperty
  a_shortBase: assert property (p_shortBase) else $error("short base wrong");
  property p_statUpper; storeSysRegInstr && sysRegNum == 5'h05 |=> sysRdData[31:8] == 24'h0;
  endproperty
  a_statUpper: assert property (p_statUpper) else $error("status upper set");
  property p_statLoad; loadSysRegInstr && !storeSysRegInstr && sysRegNum == 5'h05
    |=> {24'h0, statusOut} == ($past(sysWrData) & STAT_MASK); endproperty
  a_statLoad: assert property (p_statLoad) else $error("status load lost");
  property p_baseLoad; loadSysRegInstr && !storeSysRegInstr && sysRegNum == 5'h14
    |=> tableCallBaseOut == $past(sysWrData); endproperty
  a_baseLoad: assert property (p_baseLoad) else $error("base load lost");
  property p_storeHold; !storeSysRegInstr |=> $stable(sysRdData); endproperty
  a_storeHold: assert property (p_storeHold) else $error("read data moved");
  property p_pcWrap; pcAdvance && !pcReq.jump && !pcReq.ret
    |=> pcOut == (($past(pcOut) + $past(pcStep)) & PC_KEEP_MASK); endproperty
  a_pcWrap: assert property (p_pcWrap) else $error("pc step wrong");
endmodule
bind crs_register_set crs_register_set_monitor u_mon (.*);

// ---- crs_pipe_model.sv ----
// Pipeline model issuing register writes and system register instructions
`timescale 1ns/10ps
module crs_pipe_model
  import crs_pkg::*;
(
  input  wire logic        clk,
  output crs_pkg::crs_wr_s gprWr,
  output logic             loadSysRegInstr,
  output logic             storeSysRegInstr,
  output logic [4:0]       sysRegNum,
  output logic [XLEN-1:0]  sysWrData,
  output logic             debugTrapInstr
);
  initial begin
    gprWr = '0;
    {loadSysRegInstr, storeSysRegInstr, debugTrapInstr, sysRegNum, sysWrData} = '0;
  end
  // Reserved numbers never issued
  // No nested interrupts here, so the single save PC is never overwritten
  // Odd saved PCs in the system register test and in the return test that proves bit zero is dropped
  task automatic sysOp(input logic ld, input logic [4:0] num, input logic [31:0] d,
                       input logic dbg);
    @(posedge clk);
    loadSysRegInstr  <= ld;
    storeSysRegInstr <= !ld;
    sysRegNum        <= num;
    sysWrData        <= d;
    debugTrapInstr   <= dbg;
    @(posedge clk);
    {loadSysRegInstr, storeSysRegInstr, debugTrapInstr} <= 3'h0;
    sysWrData        <= ~d; // Stale data never lingers
  endtask
  task automatic gprWrite(input logic [4:0] idx, input logic [31:0] d);
    @(posedge clk);
    gprWr <= '{en: 1'b1, idx: idx, data: d};
    @(posedge clk);
    gprWr <= '{en: 1'b0, idx: ~idx, data: ~d};
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking testbench for the CPU register set
`timescale 1ns/10ps
module testbench;
  import crs_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, shortMemAccess = 1'b0, pcAdvance = 1'b0;
  logic [4:0] rdAddrA = '0, rdAddrB = '0, sysRegNum;
  crs_pc_s pcReq = '0;
  logic [31:0] pcStep = '0, sysWrData, causeWrData = '0;
  crs_wr_s gprWr, hwSave = '0;
  crs_stat_s flagWrData = '0, statusOut;
  logic flagWrEn = 1'b0, causeWrEn = 1'b0, loadSysRegInstr, storeSysRegInstr, debugTrapInstr;
  logic [31:0] rdDataA, rdDataB, memBase, pcOut, sysRdData, tableCallBaseOut;
  int err_count = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  crs_register_set DUT (.*);
  crs_pipe_model pipe (.*);
  function automatic logic [31:0] gv(int i);
    return (i == 0) ? 32'h0 : {8'hc3, 8'(i), 16'h8001};
  endfunction
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_gpr;
    for (int i = 0; i < 32; i++) pipe.gprWrite(5'(i), {8'hc3, 8'(i), 16'h8001});
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      rdAddrA <= 5'(i);
      rdAddrB <= 5'(31 - i);
      shortMemAccess <= i[0];
      @(posedge clk);
      #1;
      check("rdDataA", rdDataA, gv(i));
      check("rdDataB", rdDataB, gv(31 - i));
      check("memBase", memBase, i[0] ? gv(30) : gv(i));
    end
  endtask
  task automatic t_sys;
    logic [4:0] nums [11] = '{0, 1, 2, 3, 4, 5, 16, 17, 18, 19, 20};
    logic [31:0] v;
    foreach (nums[k]) begin
      v = 32'hf0e1d2c3 ^ 32'(k);
      pipe.sysOp(1'b1, nums[k], v, k == 8);
      pipe.sysOp(1'b0, nums[k], '0, 1'b0);
      #1;
      check("sysRdData", sysRdData, (nums[k] == 4 || nums[k] == 19) ? 32'h0 :
            nums[k] == 5 ? v & STAT_MASK : v);
    end
    check("statusOut", {24'h0, statusOut}, (32'hf0e1d2c3 ^ 32'h5) & STAT_MASK);
    check("tableCallBaseOut", tableCallBaseOut, 32'hf0e1d2c3 ^ 32'ha);
  endtask
  task automatic t_pc;
    logic [31:0] v;
    @(posedge clk);
    pcReq <= '{jump: 1'b1, target: 32'hfffffffb, ret: 1'b0, retSrc: CRS_RET_IRQ};
    @(posedge clk);
    pcReq.jump <= 1'b0;
    pcAdvance <= 1'b1;
    pcStep <= 32'h6;
    #1;
    check("pcOut", pcOut, 32'h03fffffa);
    @(posedge clk);
    pcAdvance <= 1'b0;
    #1;
    check("pcOut", pcOut, 32'h0);
    for (int s = 0; s < 3; s++) begin
      v = 32'hfc012341 + 32'(s) * 32'h20;
      pipe.sysOp(1'b1, s == 0 ? SR_IRQ_PC : s == 1 ? SR_NMI_PC : SR_TC_PC, v, 1'b0);
      @(posedge clk);
      pcReq <= '{jump: 1'b0, target: '0, ret: 1'b1, retSrc: crs_ret_e'(s)};
      @(posedge clk);
      pcReq.ret <= 1'b0;
      #1;
      check("pcOut", pcOut, v & PC_KEEP_MASK);
    end
  endtask
  task automatic t_hw;
    @(posedge clk);
    hwSave <= '{en: 1'b1, idx: SR_NMI_ST, data: 32'h5a5a0001};
    flagWrEn <= 1'b1;
    flagWrData <= 8'h81;
    causeWrEn <= 1'b1;
    causeWrData <= 32'h00000123;
    @(posedge clk);
    hwSave <= '0;
    flagWrEn <= 1'b0;
    causeWrEn <= 1'b0;
    #1;
    check("statusOut", {24'h0, statusOut}, 32'h00000081);
    pipe.sysOp(1'b0, SR_NMI_ST, '0, 1'b0);
    #1;
    check("sysRdData", sysRdData, 32'h5a5a0001);
    pipe.sysOp(1'b0, SR_CAUSE, '0, 1'b0);
    #1;
    check("sysRdData", sysRdData, 32'h00000123);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_gpr();
    t_sys();
    t_pc();
    t_hw();
    finish_test();
  end
  // Full run needs about 200 cycles
  initial begin
    #5000;
    err_count++;
    finish_test();
  end
endmodule
